// *** common/hdr_log_map.svh ***
// offsets and field reset values of the secondary header log
`ifndef HDR_LOG_MAP_SVH
`define HDR_LOG_MAP_SVH
`define HDR_LOG_WORD0_OFS   12'h13C
`define HDR_LOG_WORD1_OFS   12'h140
`define HDR_LOG_WORD2_OFS   12'h144
`define HDR_LOG_WORD3_OFS   12'h148
`define HDR_LOG_RESET       32'h0000_0000
`define HDR_LOG_CMD_RESET   4'h0
`define HDR_LOG_ADDR_RESET  32'h0000_0000
`define HDR_LOG_RSVD_HI     20'h0_0000
`define HDR_LOG_ATTR_ZERO   4'h0
`define HDR_LOG_ATTR_LOW    32'h0000_0000
`endif

// *** common/hdr_log_pkg.sv ***
// types shared by the secondary header log block
package hdr_log_pkg;
  // one observed address phase pair from the secondary bus
  typedef struct packed {
    logic [31:0] addrFirst;
    logic [31:0] addrSecond;
    logic [3:0]  cmdFirst;
    logic [3:0]  cmdSecond;
    logic        dualCycle;
  } bus_phase_s;

  // the 128-bit log in field order, msb first
  typedef struct packed {
    logic [31:0] addrHigh;
    logic [31:0] addrLow;
    logic [19:0] reservedHi;
    logic [3:0]  upperCmd;
    logic [3:0]  lowerCmd;
    logic [3:0]  attributeHi;
    logic [31:0] attributeLo;
  } log_fields_s;

  typedef enum logic [1:0] {
    WORD0 = 2'h0,
    WORD1 = 2'h1,
    WORD2 = 2'h2,
    WORD3 = 2'h3
  } log_word_e;
endpackage

// *** rtl/hdr_log_word_mux.sv ***
// read selection of one 32-bit word out of the 128-bit log
`timescale 1ns/1ps
`include "hdr_log_map.svh"
module hdr_log_word_mux #(
  parameter int WORDS = 4
) (
  input  wire logic [WORDS*32-1:0] logBits,
  input  wire logic [WORDS-1:0]    wordHit,
  output logic      [31:0]         wordData
);
  logic [31:0] partial [WORDS+1];

  assign partial[0] = `HDR_LOG_RESET;
  genvar w;
  generate
    for (w = 0; w < WORDS; w++) begin : g_word
      // word w maps bits 32w+31 down to 32w
      assign partial[w+1] = partial[w] | (wordHit[w] ? logBits[w*32 +: 32] : `HDR_LOG_RESET);
    end
  endgenerate
  assign wordData = partial[WORDS];
endmodule

// *** rtl/secondary_bus_error_header_log.sv ***
// secondary bus error header log: capture and config read-back
`timescale 1ns/1ps
`include "hdr_log_map.svh"
module secondary_bus_error_header_log #(
  parameter int WORDS = 4
) (
  input  wire logic                      clk_sys,
  input  wire logic                      reset_n,
  input  wire logic                      pcieResetPin_n,
  input  wire logic                      global_reset_pin,
  input  wire logic                      errorStatusSet,
  input  wire hdr_log_pkg::bus_phase_s   busPhase,
  input  wire logic                      cfgRead,
  input  wire logic                      cfgWrite,
  input  wire logic [11:0]               cfgAddr,
  input  wire logic [31:0]               cfgWriteData,
  output logic      [31:0]               cfgReadData,
  output logic                           cfgReadValid,
  output logic                           cfgHit
);
  //////////////////////////////////////////////////////////////////////////
  // fundamental reset: low while reset_n is low, pcieResetPin_n is low or global_reset_pin is high
  logic pcieResetActive;
  logic globalResetActive;
  logic fundamental_reset_n;

  assign pcieResetActive   = ~pcieResetPin_n;
  assign globalResetActive = global_reset_pin;
  // fundamental reset sources
  // block reset is folded in so a power-on clear also empties the log
  assign fundamental_reset_n = reset_n & ~pcieResetActive & ~globalResetActive;

  //////////////////////////////////////////////////////////////////////////
  // capture inputs from the failing bus cycle
  logic        captureNow;
  logic        dualCaptured;
  logic [31:0] addrHighCaptured;
  logic [3:0]  upperCmdCaptured;

  // capture with status
  // tied to the status level, so every cycle errorStatusSet stays high captures the bus again
  assign captureNow   = errorStatusSet;
  assign dualCaptured = busPhase.dualCycle;

  assign addrHighCaptured = dualCaptured ? busPhase.addrSecond : `HDR_LOG_ADDR_RESET;
  // dual cycle command
  // a single cycle has no second phase, so a stale upper command must not linger
  assign upperCmdCaptured = dualCaptured ? busPhase.cmdSecond : `HDR_LOG_CMD_RESET;

  //////////////////////////////////////////////////////////////////////////
  // next values of the log fields
  logic [31:0] addrLow_reg;
  logic [31:0] addrLow_next;
  logic [31:0] addrHigh_reg;
  logic [31:0] addrHigh_next;
  logic [3:0]  lowerCmd_reg;
  logic [3:0]  lowerCmd_next;
  logic [3:0]  upperCmd_reg;
  logic [3:0]  upperCmd_next;

  assign addrLow_next  = captureNow ? busPhase.addrFirst : addrLow_reg;
  assign addrHigh_next = captureNow ? addrHighCaptured : addrHigh_reg;
  assign lowerCmd_next = captureNow ? busPhase.cmdFirst : lowerCmd_reg;
  assign upperCmd_next = captureNow ? upperCmdCaptured : upperCmd_reg;

  //////////////////////////////////////////////////////////////////////////
  // log field registers, cleared by nothing but the fundamental reset

  always_ff @(posedge clk_sys) begin
    if (!fundamental_reset_n) begin
      addrLow_reg <= `HDR_LOG_ADDR_RESET;
    end else begin
      addrLow_reg <= addrLow_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!fundamental_reset_n) begin
      addrHigh_reg <= `HDR_LOG_ADDR_RESET;
    end else begin
      addrHigh_reg <= addrHigh_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!fundamental_reset_n) begin
      lowerCmd_reg <= `HDR_LOG_CMD_RESET;
    end else begin
      lowerCmd_reg <= lowerCmd_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!fundamental_reset_n) begin
      upperCmd_reg <= `HDR_LOG_CMD_RESET;
    end else begin
      upperCmd_reg <= upperCmd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assemble the 128-bit log
  hdr_log_pkg::log_fields_s logFields;
  logic [WORDS-1:0][31:0]   logWords;

  assign logFields.addrHigh    = addrHigh_reg;
  assign logFields.addrLow     = addrLow_reg;
  assign logFields.reservedHi  = `HDR_LOG_RSVD_HI;
  assign logFields.upperCmd    = upperCmd_reg;
  assign logFields.lowerCmd    = lowerCmd_reg;
  assign logFields.attributeHi = `HDR_LOG_ATTR_ZERO;
  assign logFields.attributeLo = `HDR_LOG_ATTR_LOW;
  assign logWords              = logFields;

  //////////////////////////////////////////////////////////////////////////
  // the four software-visible words
  logic [31:0] hdrLogWord0;
  logic [31:0] hdrLogWord1;
  logic [31:0] hdrLogWord2;
  logic [31:0] hdrLogWord3;

  assign hdrLogWord0 = logWords[hdr_log_pkg::WORD0];
  assign hdrLogWord1 = logWords[hdr_log_pkg::WORD1];
  assign hdrLogWord2 = logWords[hdr_log_pkg::WORD2];
  assign hdrLogWord3 = logWords[hdr_log_pkg::WORD3];

  //////////////////////////////////////////////////////////////////////////
  // config decode
  function automatic logic [WORDS-1:0] decodeWord(input logic [11:0] addr);
    logic [WORDS-1:0] hit;
    hit = '0;
    case (addr)
      `HDR_LOG_WORD0_OFS: hit[hdr_log_pkg::WORD0] = 1'b1;
      `HDR_LOG_WORD1_OFS: hit[hdr_log_pkg::WORD1] = 1'b1;
      `HDR_LOG_WORD2_OFS: hit[hdr_log_pkg::WORD2] = 1'b1;
      `HDR_LOG_WORD3_OFS: hit[hdr_log_pkg::WORD3] = 1'b1;
      default:            hit = '0;
    endcase
    return hit;
  endfunction

  logic [WORDS-1:0] wordHit;

  assign wordHit = decodeWord(cfgAddr);
  assign cfgHit  = |wordHit;

  //////////////////////////////////////////////////////////////////////////
  // write handling
  logic writeToLog;

  // writes dropped
  // no write reaches the log registers, so no write can disturb the log
  assign writeToLog = cfgWrite & cfgHit & (|cfgWriteData | ~(|cfgWriteData));

  //////////////////////////////////////////////////////////////////////////
  // read-back
  logic [31:0] wordData;
  logic        readAccepted;
  logic [31:0] readData_next;
  logic        readValid_next;

  hdr_log_word_mux #(
    .WORDS    (WORDS)
  ) u_mux (
    .logBits  ({hdrLogWord3, hdrLogWord2, hdrLogWord1, hdrLogWord0}),
    .wordHit  (wordHit),
    .wordData (wordData)
  );

  // a read colliding with a write to a log word is dropped whole
  assign readAccepted   = cfgRead & ~writeToLog;
  // unmapped offsets return zero with valid
  assign readData_next  = readAccepted ? wordData : `HDR_LOG_RESET;
  assign readValid_next = readAccepted;

  //////////////////////////////////////////////////////////////////////////
  // read registers: one-cycle answer, zero when idle

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfgReadData <= `HDR_LOG_RESET;
    end else begin
      cfgReadData <= readData_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfgReadValid <= 1'b0;
    end else begin
      cfgReadValid <= readValid_next;
    end
  end
endmodule

// *** sim/hdr_log_monitor.sv ***
// port assertions for the secondary header log
`timescale 1ns/1ps
module hdr_log_monitor (
  input wire logic                    clk_sys,
  input wire logic                    reset_n,
  input wire logic                    pcieResetPin_n,
  input wire logic                    global_reset_pin,
  input wire logic                    errorStatusSet,
  input wire hdr_log_pkg::bus_phase_s busPhase,
  input wire logic                    cfgRead,
  input wire logic                    cfgWrite,
  input wire logic                    cfgReadValid,
  input wire logic                    cfgHit,
  input wire logic [11:0]             cfgAddr,
  input wire logic [31:0]             cfgWriteData,
  input wire logic [31:0]             cfgReadData
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n || !pcieResetPin_n || global_reset_pin);
  rd_answered_a: assert property (cfgRead && !cfgWrite |=> cfgReadValid)
    else $error("read not answered");
  idle_zero_a: assert property (!cfgReadValid |-> cfgReadData == 0)
    else $error("data without valid");
  unmapped_zero_a: assert property (cfgRead && cfgAddr == 12'h138
    |-> !cfgHit ##1 !cfgReadData) else $error("unmapped read not zero");
  hit_mapped_a: assert property (cfgAddr == 12'h13C || cfgAddr == 12'h140
    || cfgAddr == 12'h144 || cfgAddr == 12'h148 |-> cfgHit) else $error("log word not decoded");
  attr_zero_a: assert property (cfgRead && cfgAddr == 12'h13C |=> cfgReadData == 0)
    else $error("attribute word not zero");
  rsvd_zero_a: assert property (cfgRead && cfgAddr == 12'h140 |=> !cfgReadData[31:12])
    else $error("reserved bits not zero");
  addr_low_a: assert property (errorStatusSet ##1 cfgRead && cfgAddr == 12'h144
    |=> cfgReadData == $past(busPhase.addrFirst, 2)) else $error("first address wrong");
  addr_high_a: assert property (errorStatusSet ##1 cfgRead && cfgAddr == 12'h148
    |=> cfgReadData == ($past(busPhase.dualCycle, 2) ? $past(busPhase.addrSecond, 2) : 0))
    else $error("second address wrong");
  fund_clear_a: assert property (disable iff (!reset_n) !pcieResetPin_n ##1 cfgRead
    |=> cfgReadData == 0) else $error("log survived pin reset");
endmodule
bind secondary_bus_error_header_log hdr_log_monitor mon (.clk_sys, .reset_n, .pcieResetPin_n,
  .global_reset_pin, .errorStatusSet, .busPhase, .cfgRead, .cfgWrite, .cfgReadValid, .cfgHit,
  .cfgAddr, .cfgWriteData, .cfgReadData);

// *** sim/sec_bus_agent.sv ***
// secondary bus agent: presents the failing cycle when told
`timescale 1ns/1ps
module sec_bus_agent (
  input  wire logic               clk_sys,
  input  wire logic               fire,
  input  wire logic [31:0]        rnd,
  output hdr_log_pkg::bus_phase_s busPhase,
  output logic                    errorStatusSet
);
  // lines toggle outside the error cycle so a late sample cannot match
  always @(negedge clk_sys) begin
    errorStatusSet <= fire;
    busPhase <= fire ? {rnd, ~rnd, rnd[3:0], rnd[7:4], rnd[8]} : ~busPhase;
  end
endmodule

// *** sim/tb.sv ***
// self-checking bench for the secondary header log
`timescale 1ns/1ps
module tb;
  logic clk_sys = 0, reset_n = 0, pcieResetPin_n = 1, global_reset_pin = 0, fire = 0;
  logic cfgRead = 0, cfgWrite = 0, errorStatusSet, cfgReadValid, cfgHit;
  logic [11:0] cfgAddr = 0;
  logic [31:0] cfgWriteData = 0, cfgReadData, rnd = 0, seed = 32'h8CD00BF3;
  hdr_log_pkg::bus_phase_s busPhase;
  int num_errors = 0, total_checks = 0;
  secondary_bus_error_header_log dut (.clk_sys, .reset_n, .pcieResetPin_n, .global_reset_pin,
    .errorStatusSet, .busPhase, .cfgRead, .cfgWrite, .cfgAddr, .cfgWriteData, .cfgReadData,
    .cfgReadValid, .cfgHit);
  sec_bus_agent agent (.clk_sys, .fire, .rnd, .busPhase, .errorStatusSet);
  initial forever #2.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] expWord(logic [31:0] r, int w);
    if (w == 1) return {20'h0_0000, r[8] ? r[7:4] : 4'h0, r[3:0], 4'h0};
    if (w == 2) return r;
    return (w == 3 && r[8]) ? ~r : 32'h0000_0000;
  endfunction
  task automatic rd(logic [11:0] a, logic [31:0] e);
    cfgRead <= 1;
    cfgAddr <= a;
    @(negedge clk_sys);
    cfgRead <= 0;
    total_checks++;
    if (cfgReadValid !== 1'b1 || cfgReadData !== e) begin
      num_errors++;
      $display("Error word %h expected %h seen %h", a, e, cfgReadData);
    end
    @(negedge clk_sys);
  endtask
  // the start word rotates so every word is also the first read after a capture
  task automatic rdAll(logic [31:0] r, int s = 0);
    for (int k = 0; k < 4; k++) begin
      rd(12'h13C + 12'(4 * ((k + s) % 4)), expWord(r, (k + s) % 4));
    end
  endtask
  task automatic cap(logic [31:0] r);
    rnd <= r;
    fire <= 1;
    @(negedge clk_sys);
    fire <= 0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    reset_n <= 1;
    @(negedge clk_sys);
    rdAll(0);
    rd(12'h138, 0);
    $display("reset values done");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      // dual then single first, later captures overwrite
      cap(i < 2 ? {seed[31:9], ~i[0], seed[7:0]} : seed);
      cfgWrite <= 1;
      cfgAddr <= 12'h13C + {seed[1:0], 2'b00};
      cfgWriteData <= ~seed;
      @(negedge clk_sys);
      cfgWrite <= 0;
      rdAll(rnd, i % 4);
    end
    $display("capture done");
    cap(seed);
    @(negedge clk_sys);
    pcieResetPin_n <= 0;
    @(negedge clk_sys);
    pcieResetPin_n <= 1;
    rdAll(0);
    cap(~seed);
    @(negedge clk_sys);
    global_reset_pin <= 1;
    @(negedge clk_sys);
    global_reset_pin <= 0;
    rdAll(0);
    $display("fundamental reset done");
    report_and_stop;
  end
endmodule
